/* File: rtl/clb_pkg.sv */
// constants of the two-table configurable glue logic block
// assumes one system clock; all settings arrive on plain write strobes
//
// Contract
// R1 - pair mode selection only writable while the even table is disabled
// R2 - table control fields except enable only writable while that table is disabled
// R3 - protected fields take effect with an enabling write, not with a disabling one
// R4 - writing one switches whole block on, writing zero switches it off
// R5 - each table enabled or disabled by its own enable bit
// R6 - table output is the truth bit indexed by input two, one, zero
// R7 - a masked input presents a constant zero
// R8 - feedback selection on inputs zero and one carries the pair output
// R9 - link selection carries the direct output of table one into table zero
// R10 - event lines zero and one are selectable for any input
// R11 - software routes events before selecting them as inputs
// R12 - pin selection connects the input to its dedicated pin
// R13 - inputs zero, one select in second register; input two in third
// R14 - filtered output follows the table output after two to five table clocks
// R15 - filter state cleared one clock after the table is disabled
// R16 - edge detector pulses on each rising edge of its input
// R17 - software pairs the edge detector with a synchronizer or filter
// R18 - edge detector state cleared one clock after disable; zero bit turns it off
// R19 - pair element takes the post-filter outputs, function set by mode field
// R20 - pair element runs on the even table clock: system clock or input two; the latch modes update on every system clock
// R21 - disabling the even table clears the pair element within one clock
// R22 - gated d modes: even is d, odd is g; g high follows, low holds
// R23 - jk mode: hold, clear, set, toggle from even j and odd k
// R24 - set-reset latch: even sets, odd clears, both high must be avoided
// R25 - mode codes: 0 off, 1 d flop, 2 jk, 3 d latch, 4 set-reset
// R26 - filter codes: 0 none, 1 synchronizer, 2 filter, 3 reserved
// R27 - input two reads as masked while it clocks the table
// R28 - a disabled table drives constant zero
package clb_pkg;
   // first control register fields
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_OUTEN_BIT = 3;
   localparam int CTL_FILT_LSB = 4;
   localparam int CTL_CLOCK_SOURCE_BIT = 6;
   localparam int CTL_EDGE_BIT = 7;
   // second and third control register fields
   localparam int SEL0_LSB = 0;
   localparam int SEL1_LSB = 4;
   localparam int SEL2_LSB = 0;
   // reset values
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] TRUTH_RESET = 8'h00;
   localparam logic [3:0] MODE_RESET = 4'h0;
   // pair mode codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] GATED_D_FLOP_MODE = 4'h1;
   localparam logic [3:0] JK_FLOP_MODE = 4'h2;
   localparam logic [3:0] GATED_D_LATCH_MODE = 4'h3;
   localparam logic [3:0] SET_RESET_LATCH_MODE = 4'h4;
   // output filter codes
   localparam logic [1:0] FILT_NONE = 2'h0;
   localparam logic [1:0] FILT_SYNC = 2'h1;
   localparam logic [1:0] FILT_FILTER = 2'h2;
   // input source codes, unlisted codes read as masked
   localparam logic [3:0] SRC_MASKED = 4'h0;
   localparam logic [3:0] SRC_FEEDBACK = 4'h1;
   localparam logic [3:0] SRC_LINK = 4'h2;
   localparam logic [3:0] SRC_EVENT_ZERO = 4'h3;
   localparam logic [3:0] SRC_EVENT_ONE = 4'h4;
   localparam logic [3:0] SRC_PIN = 4'h5;
   localparam logic [3:0] SRC_PERIPH_A = 4'h6;
   localparam logic [3:0] SRC_PERIPH_B = 4'h7;
   // timing counts: filter delays in table clocks, clear delay in system clocks
   localparam int FILT_MIN_CYC = 2;
   localparam int FILT_MAX_CYC = 5;
   localparam int CLEAR_CYC = 1;
endpackage

/* File: rtl/clb_custom_logic_block.sv */
// two three-input lookup tables sharing one sequential pair element
// assumes all inputs synchronous to i_clk; settings arrive as write strobes
`timescale 1ns/100ps
`default_nettype none

module clb_custom_logic_block (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // block enable write
   input wire logic i_glob_wr,
   input wire logic i_glob_enable,
   // pair mode write
   input wire logic i_mode_wr,
   input wire logic [3:0] i_mode_wdata,
   // per-table register writes, one strobe bit per table
   input wire logic [1:0] i_first_wr,
   input wire logic [1:0] i_second_wr,
   input wire logic [1:0] i_third_wr,
   input wire logic [1:0] i_truth_wr,
   input wire logic [7:0] i_wdata,
   // signal sources
   input wire logic i_event_line_zero,
   input wire logic i_event_line_one,
   input wire logic [2:0] i_pin_in_t0,
   input wire logic [2:0] i_pin_in_t1,
   input wire logic [1:0] i_periph_a,
   input wire logic [1:0] i_periph_b,
   // status
   output logic o_block_enable,
   output logic [1:0] o_table_enable,
   output logic [3:0] o_seq_mode_select,
   // results
   output logic [1:0] o_table_out,
   output logic [1:0] o_pin_out,
   output logic [1:0] o_pin_oe,
   output logic o_pair_out
);

   // ==========================================================
   // source selection
   function automatic logic pick_source(input logic [3:0] sel, input logic fb,
         input logic lnk, input logic pin, input logic pa, input logic pb);
      logic v;
      v = 1'b0;
      unique case (sel)
         clb_pkg::SRC_FEEDBACK: v = fb; // [R8]
         clb_pkg::SRC_LINK: v = lnk; // [R9]
         clb_pkg::SRC_EVENT_ZERO: v = i_event_line_zero; // [R10]
         clb_pkg::SRC_EVENT_ONE: v = i_event_line_one; // [R10]
         clb_pkg::SRC_PIN: v = pin; // [R12]
         clb_pkg::SRC_PERIPH_A: v = pa;
         clb_pkg::SRC_PERIPH_B: v = pb;
         default: v = 1'b0; // [R7]
      endcase
      return v;
   endfunction

   // ==========================================================
   // state and per-table signals
   logic glob_ff;
   logic [3:0] mode_ff;
   logic pair_ff;
   logic nxt_pair;
   logic [7:0] ctl_ff [2];
   logic [7:0] sel_b_ff [2];
   logic [3:0] sel_c_ff [2];
   logic [7:0] truth_ff [2];
   logic [3:0] sh_ff [2];
   logic flt_ff [2];
   logic edge_prev_ff [2];
   logic in2_prev_ff [2];
   logic [1:0] active;
   logic [1:0] direct;
   logic [1:0] stage;
   logic [1:0] tclk_en;
   logic [1:0] filtered;
   logic [2:0] idx [2];
   logic [2:0] pins [2];

   assign pins[0] = i_pin_in_t0;
   assign pins[1] = i_pin_in_t1;

   // block enable follows each write of its bit
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         glob_ff <= 1'b0;
      end else if (i_glob_wr) begin
         glob_ff <= i_glob_enable; // [R4]
      end
   end

   // pair mode, locked while the even table runs
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mode_ff <= clb_pkg::MODE_RESET;
      end else if (i_mode_wr && !ctl_ff[0][clb_pkg::CTL_ENABLE_BIT]) begin
         mode_ff <= i_mode_wdata; // [R1]
      end
   end

   // ==========================================================
   // lookup tables
   for (genvar t = 0; t < 2; t++) begin : g_tab
      logic en;
      logic csrc;
      logic edge_on;
      logic [1:0] fsel;
      logic lnk;
      logic in0;
      logic in1;
      logic in2_raw;
      logic in2;

      assign en = ctl_ff[t][clb_pkg::CTL_ENABLE_BIT];
      assign csrc = ctl_ff[t][clb_pkg::CTL_CLOCK_SOURCE_BIT];
      assign edge_on = ctl_ff[t][clb_pkg::CTL_EDGE_BIT];
      assign fsel = ctl_ff[t][clb_pkg::CTL_FILT_LSB +: 2];
      assign active[t] = glob_ff & en; // [R4] [R5]

      // configuration registers, protected fields only while disabled
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            ctl_ff[t] <= clb_pkg::CTL_RESET;
            sel_b_ff[t] <= clb_pkg::CTL_RESET;
            sel_c_ff[t] <= clb_pkg::CTL_RESET[3:0];
            truth_ff[t] <= clb_pkg::TRUTH_RESET;
         end else begin
            if (i_first_wr[t]) begin
               ctl_ff[t][0] <= i_wdata[0]; // [R5]
               if (!en) begin
                  ctl_ff[t][7:1] <= {i_wdata[7:3], 2'h0}; // [R2] [R3]
               end
            end
            if (i_second_wr[t] && !en) begin
               sel_b_ff[t] <= i_wdata; // [R2] [R13]
            end
            if (i_third_wr[t] && !en) begin
               sel_c_ff[t] <= i_wdata[3:0]; // [R2] [R13]
            end
            if (i_truth_wr[t]) begin
               truth_ff[t] <= i_wdata;
            end
         end
      end

      // input muxes; only table zero has a higher neighbour
      assign lnk = (t == 0) ? direct[1] : 1'b0; // [R9]
      assign in0 = pick_source(sel_b_ff[t][clb_pkg::SEL0_LSB +: 4], pair_ff, lnk,
         pins[t][0], i_periph_a[t], i_periph_b[t]);
      assign in1 = pick_source(sel_b_ff[t][clb_pkg::SEL1_LSB +: 4], pair_ff, lnk,
         pins[t][1], i_periph_a[t], i_periph_b[t]);
      assign in2_raw = pick_source(sel_c_ff[t][clb_pkg::SEL2_LSB +: 4], 1'b0, lnk,
         pins[t][2], i_periph_a[t], i_periph_b[t]);
      assign in2 = in2_raw & ~csrc; // [R27]
      assign idx[t] = {in2, in1, in0};
      assign direct[t] = active[t] & truth_ff[t][idx[t]]; // [R6] [R28]

      // table clock: every cycle, or one pulse per rising input two
      assign tclk_en[t] = csrc ? (in2_raw & ~in2_prev_ff[t]) : 1'b1; // [R20]

      // filter and edge stage, cleared on the first clock while disabled
      always_ff @(posedge i_clk) begin
         if (i_reset || !active[t]) begin
            sh_ff[t] <= 4'h0; // [R15]
            flt_ff[t] <= 1'b0; // [R15]
            edge_prev_ff[t] <= 1'b0; // [R18]
         end else if (tclk_en[t]) begin
            sh_ff[t] <= {sh_ff[t][2:0], direct[t]};
            if (sh_ff[t][3:1] == {3{sh_ff[t][1]}}) begin
               flt_ff[t] <= sh_ff[t][1]; // [R14]
            end
            edge_prev_ff[t] <= filtered[t];
         end
      end

      // edge history of input two runs always so the clock pulse is clean
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            in2_prev_ff[t] <= 1'b0;
         end else begin
            in2_prev_ff[t] <= in2_raw;
         end
      end

      // stage output: synchronizer two clocks, filter five
      assign filtered[t] = (fsel == clb_pkg::FILT_SYNC) ? sh_ff[t][1] :
         (fsel == clb_pkg::FILT_FILTER) ? flt_ff[t] : direct[t]; // [R14] [R26]
      assign stage[t] = active[t] &
         (edge_on ? (filtered[t] & ~edge_prev_ff[t]) : filtered[t]); // [R16] [R18]
      assign o_pin_out[t] = stage[t];
      assign o_pin_oe[t] = active[t] & ctl_ff[t][clb_pkg::CTL_OUTEN_BIT];
      assign o_table_enable[t] = en;
   end

   // ==========================================================
   // pair element: even drives d/j/s, odd drives g/k/r
   always_comb begin
      nxt_pair = pair_ff;
      unique case (mode_ff)
         clb_pkg::GATED_D_FLOP_MODE: begin
            if (tclk_en[0] && stage[1]) begin
               nxt_pair = stage[0]; // [R22]
            end
         end
         clb_pkg::JK_FLOP_MODE: begin
            if (tclk_en[0]) begin
               unique case ({stage[0], stage[1]})
                  2'b01: nxt_pair = 1'b0; // [R23]
                  2'b10: nxt_pair = 1'b1;
                  2'b11: nxt_pair = ~pair_ff;
                  2'b00: nxt_pair = pair_ff;
               endcase
            end
         end
         clb_pkg::GATED_D_LATCH_MODE: begin
            if (stage[1]) begin
               nxt_pair = stage[0]; // [R22]
            end
         end
         clb_pkg::SET_RESET_LATCH_MODE: begin
            if (stage[0] && !stage[1]) begin
               nxt_pair = 1'b1; // [R24]
            end else if (stage[1] && !stage[0]) begin
               nxt_pair = 1'b0;
            end
         end
         default: nxt_pair = 1'b0; // [R25]
      endcase
   end

   // latch modes follow at system clock rate, flop modes on the even table clock
   always_ff @(posedge i_clk) begin
      if (i_reset || !active[0]) begin
         pair_ff <= 1'b0; // [R21]
      end else begin
         pair_ff <= nxt_pair; // [R19] [R20]
      end
   end

   // outputs
   assign o_block_enable = glob_ff;
   assign o_seq_mode_select = mode_ff;
   assign o_table_out = stage;
   assign o_pair_out = pair_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   sequence s_filter_high;
      (active[0] && direct[0] && !ctl_ff[0][clb_pkg::CTL_CLOCK_SOURCE_BIT] &&
       ctl_ff[0][clb_pkg::CTL_FILT_LSB +: 2] == clb_pkg::FILT_FILTER) [*5];
   endsequence

   sequence s_jk_toggle;
      active[0] && mode_ff == clb_pkg::JK_FLOP_MODE && tclk_en[0] && stage[0] && stage[1];
   endsequence

   chk_mode_locked: assert property (i_mode_wr && ctl_ff[0][0] |=> $stable(mode_ff)) // [R1]
      else $error("pair mode changed while even table enabled");
   chk_sel_locked: assert property (i_second_wr[0] && ctl_ff[0][0] |=> $stable(sel_b_ff[0])) // [R2]
      else $error("selector changed while table enabled");
   chk_enable_write: assert property (i_first_wr[0] && !ctl_ff[0][0] && i_wdata[0]
      |=> ctl_ff[0] == {$past(i_wdata[7:3]), 3'h1}) // [R3]
      else $error("enabling write lost protected fields");
   chk_block_enable: assert property (i_glob_wr |=> glob_ff == $past(i_glob_enable)) // [R4]
      else $error("block enable did not follow write");
   chk_lut_lookup: assert property (active[0] |-> direct[0] == truth_ff[0][idx[0]]) // [R6]
      else $error("table output not the indexed truth bit");
   chk_masked_zero: assert property (sel_b_ff[0][3:0] == clb_pkg::SRC_MASKED |-> !idx[0][0]) // [R7]
      else $error("masked input not zero");
   chk_filter_delay: assert property (s_filter_high |=> filtered[0]) // [R14]
      else $error("filter output late");
   chk_filter_clear: assert property (!active[0] |=> sh_ff[0] == 4'h0 && !flt_ff[0]
      && !edge_prev_ff[0]) // [R15]
      else $error("filter state not cleared");
   chk_pair_clear: assert property (!active[0] |=> !pair_ff) // [R21]
      else $error("pair element not cleared");
   chk_jk_toggle: assert property (s_jk_toggle |=> pair_ff != $past(pair_ff)) // [R23]
      else $error("jk mode did not toggle");
   chk_off_zero: assert property (!active[1] |-> !o_table_out[1] && !direct[1]) // [R28]
      else $error("disabled table output not zero");
   // input two must never index the truth pattern while it acts as the clock
   chk_clock_mask: assert property (ctl_ff[0][clb_pkg::CTL_CLOCK_SOURCE_BIT] |-> !idx[0][2]) // [R27]
      else $error("clocking input two reached the index");

endmodule

`default_nettype wire

/* File: verification/clb_src_model.sv */
// far-side source model: event lines, dedicated pins and peripheral lines
// assumes the bench hands over the wanted levels once per system clock
`timescale 1ns/100ps
`default_nettype none

module clb_src_model (
   // clock and requested levels
   input wire logic i_clk,
   input wire logic [11:0] i_req,
   // source lines seen by the block
   output logic o_ev0,
   output logic o_ev1,
   output logic [2:0] o_pin_t0,
   output logic [2:0] o_pin_t1,
   output logic [1:0] o_pa,
   output logic [1:0] o_pb
);
   // ==========================================
   // sources move just after an edge; events are routed before any use
   always_ff @(posedge i_clk) begin
      {o_pb, o_pa, o_ev1, o_ev0, o_pin_t1, o_pin_t0} <= i_req;
   end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the two-table glue logic block
// assumes the source model sits on every signal-source input
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module tb_top;
   // ==========================================
   // stimulus and observed signals
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_glob_wr = 1'b0, i_glob_enable = 1'b0, i_mode_wr = 1'b0;
   logic [3:0] i_mode_wdata = 4'h0;
   logic [1:0] i_first_wr = 2'h0, i_second_wr = 2'h0, i_third_wr = 2'h0, i_truth_wr = 2'h0;
   logic [7:0] i_wdata = 8'h00;
   logic [11:0] req = 12'h000;
   logic i_event_line_zero, i_event_line_one;
   logic [2:0] i_pin_in_t0, i_pin_in_t1;
   logic [1:0] i_periph_a, i_periph_b, o_table_enable, o_table_out, o_pin_out, o_pin_oe;
   logic [3:0] o_seq_mode_select;
   logic o_block_enable, o_pair_out;
   int fail_count = 0;
   int checked = 0;
   int n;
   logic [7:0] pat = 8'hb4;
   int bp [6] = '{3, 6, 7, 0, 8, 10};
   logic [3:0] ta [4] = '{4'hd, 4'h7, 4'hd, 4'h9};
   logic [3:0] tb [4] = '{4'hb, 4'he, 4'hb, 4'h4};
   logic [3:0] te [4] = '{4'h9, 4'h5, 4'h9, 4'hb};

   // clock and instances
   always #50 i_clk = ~i_clk;
   clb_custom_logic_block u_dut (.i_clk, .i_reset, .i_glob_wr, .i_glob_enable, .i_mode_wr,
      .i_mode_wdata, .i_first_wr, .i_second_wr, .i_third_wr, .i_truth_wr, .i_wdata,
      .i_event_line_zero, .i_event_line_one, .i_pin_in_t0, .i_pin_in_t1, .i_periph_a,
      .i_periph_b, .o_block_enable, .o_table_enable, .o_seq_mode_select, .o_table_out,
      .o_pin_out, .o_pin_oe, .o_pair_out);
   clb_src_model u_src (.i_clk(i_clk), .i_req(req), .o_ev0(i_event_line_zero),
      .o_ev1(i_event_line_one), .o_pin_t0(i_pin_in_t0), .o_pin_t1(i_pin_in_t1),
      .o_pa(i_periph_a), .o_pb(i_periph_b));

   // ==========================================
   // write one register: 0 block, 1 mode, 2 first, 3 second, 4 third, 5 truth
   task automatic wr(input int k, input logic [1:0] m, input logic [7:0] d);
      @(posedge i_clk);
      i_glob_wr <= (k == 0);
      i_glob_enable <= d[0];
      i_mode_wr <= (k == 1);
      i_mode_wdata <= d[3:0];
      i_first_wr <= (k == 2) ? m : 2'h0;
      i_second_wr <= (k == 3) ? m : 2'h0;
      i_third_wr <= (k == 4) ? m : 2'h0;
      i_truth_wr <= (k == 5) ? m : 2'h0;
      i_wdata <= d;
      @(posedge i_clk);
      {i_glob_wr, i_mode_wr, i_first_wr, i_second_wr, i_third_wr, i_truth_wr} <= '0;
      @(negedge i_clk);
   endtask

   // set source levels and let them settle
   task automatic src(input logic [11:0] v);
      @(posedge i_clk);
      req <= v;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   // cycles until table zero goes high, bounded
   task automatic meas(input logic [11:0] v, output int c);
      @(posedge i_clk);
      req <= v;
      @(posedge i_clk);
      for (c = 0; c < 9; c++) begin
         @(negedge i_clk);
         if (o_table_out[0] === 1'b1) break;
         @(posedge i_clk);
      end
   endtask

   // high cycles of table zero over eight cycles
   task automatic cnt_hi(input logic [11:0] v, output int c);
      @(posedge i_clk);
      req <= v;
      c = 0;
      repeat (8) begin
         @(negedge i_clk);
         c += (o_table_out[0] === 1'b1);
      end
   endtask

   task automatic final_report;
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      @(negedge i_clk);
      `CHK({o_block_enable, o_table_enable, o_seq_mode_select, o_table_out, o_pair_out}, 10'h0)
      wr(0, 2'h0, 8'h01);
      `CHK(o_block_enable, 1'b1)
      // table zero indexed by its three pins
      wr(3, 2'h3, 8'h55);
      wr(4, 2'h3, 8'h05);
      wr(5, 2'h1, pat);
      wr(2, 2'h1, 8'h01);
      for (int i = 0; i < 8; i++) begin
         src(12'(i));
         `CHK(o_table_out[0], pat[i])
      end
      // locked fields, block off, enable-time load
      wr(3, 2'h1, 8'h00);
      wr(2, 2'h1, 8'h09);
      `CHK({o_table_enable, o_pin_oe[0], o_table_out[0]}, 4'h5)
      wr(0, 2'h0, 8'h00);
      `CHK({o_block_enable, o_table_out[0]}, 2'h0)
      wr(0, 2'h0, 8'h01);
      wr(2, 2'h1, 8'h00);
      `CHK({o_table_enable, o_table_out[0]}, 3'h0)
      wr(2, 2'h1, 8'h09);
      `CHK({o_pin_oe[0], o_pin_out[0]}, 2'h3)
      // all inputs masked
      wr(2, 2'h1, 8'h00);
      wr(3, 2'h1, 8'h00);
      wr(4, 2'h1, 8'h00);
      wr(2, 2'h1, 8'h01);
      wr(5, 2'h1, 8'h01);
      src(12'hfff);
      `CHK(o_table_out[0], 1'b1)
      // source codes two to seven on input zero, table one linked in
      wr(5, 2'h3, 8'haa);
      wr(2, 2'h2, 8'h01);
      `CHK(o_table_enable, 2'h3)
      for (int c = 0; c < 6; c++) begin
         wr(2, 2'h1, 8'h00);
         wr(3, 2'h1, 8'(c + 2));
         wr(2, 2'h1, 8'h01);
         for (int v = 0; v < 2; v++) begin
            src(12'(v) << bp[c]);
            `CHK(o_table_out[0], 1'(v))
         end
      end
      // synchronizer and filter delays, then state clear
      wr(2, 2'h1, 8'h00);
      wr(3, 2'h1, 8'h05);
      for (int f = 1; f < 3; f++) begin
         wr(2, 2'h1, 8'h00);
         src(12'h000);
         wr(2, 2'h1, 8'(f * 16 + 1));
         meas(12'h001, n);
         `CHK(1'(n >= 2 && n <= 5), 1'b1)
      end
      wr(2, 2'h1, 8'h00);
      wr(2, 2'h1, 8'h11);
      `CHK(o_table_out[0], 1'b0)
      // edge detector paired with the synchronizer
      wr(2, 2'h1, 8'h00);
      src(12'h000);
      wr(2, 2'h1, 8'h91);
      cnt_hi(12'h001, n);
      `CHK(n, 1)
      cnt_hi(12'h000, n);
      `CHK(n, 0)
      wr(2, 2'h1, 8'h00);
      wr(2, 2'h1, 8'h11);
      cnt_hi(12'h001, n);
      `CHK(1'(n > 1), 1'b1)
      // pair element in each mode; set-reset never gets both high
      for (int m = 1; m < 5; m++) begin
         wr(2, 2'h1, 8'h00);
         @(negedge i_clk);
         `CHK(o_pair_out, 1'b0)
         wr(1, 2'h0, 8'(m));
         wr(2, 2'h1, 8'h01);
         wr(1, 2'h0, 8'h00);
         `CHK(o_seq_mode_select, 4'(m))
         for (int s = 0; s < 4; s++) begin
            @(posedge i_clk);
            req <= {8'h00, tb[m - 1][s], 2'h0, ta[m - 1][s]};
            @(posedge i_clk);
            req <= 12'h000;
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            `CHK(o_pair_out, te[m - 1][s])
         end
      end
      // table one reads the pair output back
      wr(2, 2'h2, 8'h00);
      wr(3, 2'h2, 8'h01);
      wr(2, 2'h2, 8'h01);
      `CHK(o_table_out[1], 1'b1)
      // input two only reaches the index while it does not clock the table
      wr(2, 2'h1, 8'h00);
      wr(4, 2'h1, 8'h05);
      wr(5, 2'h1, 8'h10);
      wr(2, 2'h1, 8'h01);
      src(12'h004);
      `CHK(o_table_out[0], 1'b1)
      wr(2, 2'h1, 8'h00);
      wr(2, 2'h1, 8'h41);
      src(12'h004);
      `CHK(o_table_out[0], 1'b0)
      final_report();
   end
endmodule
`default_nettype wire
